/* File: rtl/pwt_or_matrix.sv */
// assignment matrix: ORs enabled sources onto each trigger output
`timescale 1ns/10ps
module pwt_or_matrix
	import pwt_pkg::*;
(
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	input  wire logic [NSRC-1:0]      src,
	input  wire logic [NSRC-1:0]      act,
	input  wire logic [NOUT*NSRC-1:0] asgn,
	output logic      [NOUT-1:0]      trig_q
);

	genvar k;
	generate
		for (k = 0; k < NOUT; k++) begin : g_out
			logic [NSRC-1:0] used;
			// an inactive source is masked even if its bit lingers
			assign used = src & act & asgn[k*NSRC +: NSRC];

			always_ff @(posedge aclk) begin
				if (!aresetn)
					trig_q[k] <= 1'b0;
				else
					trig_q[k] <= |used;
			end

			a_or_combine: assert property (
				@(posedge aclk) disable iff (!aresetn)
				(|(src & act & asgn[k*NSRC +: NSRC])) |=> trig_q[k]
			) else $error("assigned active source did not raise output");

			a_inactive_silent: assert property (
				@(posedge aclk) disable iff (!aresetn)
				((src & act) == '0) |=> !trig_q[k]
			) else $error("output high with no active source high");
		end
	endgenerate

endmodule : pwt_or_matrix

/* File: rtl/pwt_pkg.sv */
// constants, types and helpers for the position window trigger matrix
package pwt_pkg;

	// --------------------------------------------------------------
	// sizes
	// --------------------------------------------------------------
	localparam int NCH   = 4;
	localparam int NSRC  = 8;
	localparam int NOUT  = 4;
	localparam int NDOUT = 4;
	localparam int POS_W = 32;
	localparam int ANG_W = 16;
	localparam int ADR_W = 8;
	localparam int SEL_W = 4;

	// --------------------------------------------------------------
	// register map (byte addresses)
	// --------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STAT = 8'h04;
	localparam logic [7:0] ADDR_DSEL = 8'h0C;
	localparam logic [3:0] PAGE_ASGN = 4'h1;
	localparam logic [2:0] PAGE_POSE = 3'h1;
	localparam logic [2:0] PAGE_ROTE = 3'h2;

	// field positions
	localparam int CTRL_INV_LSB  = 8;
	localparam int STAT_TRIG_LSB = 8;
	localparam int STAT_DOUT_LSB = 12;

	// reset values
	localparam logic [15:0] CTRL_RST = 16'h0000;
	localparam logic [15:0] DSEL_RST = 16'h0000;
	localparam logic [7:0]  ASGN_RST = 8'h00;
	localparam logic [31:0] EDGE_RST = 32'h0000_0000;

	// angle in tenths of a degree: -1800 .. +1800
	localparam logic signed [15:0] ANG_MIN = 16'hF8F8;
	localparam logic signed [15:0] ANG_MAX = 16'h0708;
	localparam logic [3:0]         SEL_MAX = 4'h4;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	typedef enum logic [2:0] {
		RG_CTRL = 3'b000,
		RG_STAT = 3'b001,
		RG_DSEL = 3'b010,
		RG_ASGN = 3'b011,
		RG_POSE = 3'b100,
		RG_ROTE = 3'b101,
		RG_NONE = 3'b111
	} pwt_rg_t;

	function automatic pwt_rg_t addr_region(input logic [7:0] a);
		pwt_rg_t r;
		r = RG_NONE;
		if (a[1:0] == 2'h0) begin
			if (a == ADDR_CTRL)
				r = RG_CTRL;
			else if (a == ADDR_STAT)
				r = RG_STAT;
			else if (a == ADDR_DSEL)
				r = RG_DSEL;
			else if (a[7:4] == PAGE_ASGN)
				r = RG_ASGN;
			else if (a[7:5] == PAGE_POSE)
				r = RG_POSE;
			else if (a[7:5] == PAGE_ROTE)
				r = RG_ROTE;
		end
		return r;
	endfunction : addr_region

	function automatic logic [31:0] strb_merge(input logic [31:0] old,
	                                           input logic [31:0] nw,
	                                           input logic [3:0]  strb);
		logic [31:0] m;
		m = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b])
				m[8*b +: 8] = nw[8*b +: 8];
		end
		return m;
	endfunction : strb_merge

endpackage : pwt_pkg

/* File: rtl/pwt_top.sv */
// position window trigger matrix with axi4-lite register slave
`timescale 1ns/10ps
module pwt_top
	import pwt_pkg::*;
(
	input  wire logic                    aclk,
	input  wire logic                    aresetn,
	input  wire logic [ADR_W-1:0]        s_axi_awaddr,
	input  wire logic                    s_axi_awvalid,
	output logic                         s_axi_awready,
	input  wire logic [31:0]             s_axi_wdata,
	input  wire logic [3:0]              s_axi_wstrb,
	input  wire logic                    s_axi_wvalid,
	output logic                         s_axi_wready,
	output logic [1:0]                   s_axi_bresp,
	output logic                         s_axi_bvalid,
	input  wire logic                    s_axi_bready,
	input  wire logic [ADR_W-1:0]        s_axi_araddr,
	input  wire logic                    s_axi_arvalid,
	output logic                         s_axi_arready,
	output logic [31:0]                  s_axi_rdata,
	output logic [1:0]                   s_axi_rresp,
	output logic                         s_axi_rvalid,
	input  wire logic                    s_axi_rready,
	input  wire logic signed [POS_W-1:0] act_pos,
	input  wire logic signed [ANG_W-1:0] enc_angle,
	output logic [NOUT-1:0]              trig_out,
	output logic [NDOUT-1:0]             dout
);

	// --------------------------------------------------------------
	// configuration state
	// --------------------------------------------------------------
	logic [15:0]             ctrl_q;
	logic [15:0]             dsel_q;
	logic [NSRC-1:0]         asgn_q [NOUT];
	logic signed [POS_W-1:0] pos_edge_q [2*NCH];
	logic signed [ANG_W-1:0] rot_edge_q [2*NCH];
	logic [NSRC-1:0]         src_q;
	logic [NOUT-1:0]         trig_q;
	logic [NDOUT-1:0]        dout_q;
	logic [NOUT*NSRC-1:0]    asgn_flat;

	logic                    awready_q;
	logic                    wready_q;
	logic                    bvalid_q;
	logic [1:0]              bresp_q;
	logic [ADR_W-1:0]        awaddr_q;
	logic [31:0]             wdata_q;
	logic [3:0]              wstrb_q;
	logic                    arready_q;
	logic                    rvalid_q;
	logic [1:0]              rresp_q;
	logic [31:0]             rdata_q;

	logic [NSRC-1:0] act;
	logic [NSRC-1:0] inv;
	assign act = ctrl_q[NSRC-1:0];
	assign inv = ctrl_q[CTRL_INV_LSB +: NSRC];

	// --------------------------------------------------------------
	// register read view, shared by reads and write merging
	// --------------------------------------------------------------
	function automatic logic [31:0] rd_word(input logic [7:0] a);
		logic [31:0] v;
		v = 32'h0000_0000;
		case (addr_region(a))
			RG_CTRL: v[15:0] = ctrl_q;
			RG_STAT: begin
				v[NSRC-1:0] = src_q;
				v[STAT_TRIG_LSB +: NOUT] = trig_q;
				v[STAT_DOUT_LSB +: NDOUT] = dout_q;
			end
			RG_DSEL: v[15:0] = dsel_q;
			RG_ASGN: v[NSRC-1:0] = asgn_q[a[3:2]];
			RG_POSE: v = pos_edge_q[a[4:2]];
			RG_ROTE: v = {{(32-ANG_W){rot_edge_q[a[4:2]][ANG_W-1]}},
			              rot_edge_q[a[4:2]]};
			default: v = 32'h0000_0000;
		endcase
		return v;
	endfunction : rd_word

	// --------------------------------------------------------------
	// write check
	// --------------------------------------------------------------
	logic        wr_do;
	pwt_rg_t     wr_rg;
	logic [31:0] wr_m;
	logic [1:0]  wr_resp;
	logic [1:0]  wr_k;
	logic        wr_mix;
	logic        wr_blk;

	assign wr_do = !awready_q && !wready_q && !bvalid_q;
	assign wr_rg = addr_region(awaddr_q);
	always_comb wr_m = strb_merge(rd_word(awaddr_q), wdata_q, wstrb_q);
	assign wr_k  = awaddr_q[3:2];
	assign wr_mix = (|wr_m[3:0]) && (|wr_m[7:4]);
	assign wr_blk = (|wr_m[7:4]) && (|asgn_q[wr_k][3:0]);

	always_comb begin
		wr_resp = RESP_OKAY;
		case (wr_rg)
			RG_CTRL, RG_POSE: wr_resp = RESP_OKAY;
			RG_STAT: wr_resp = RESP_SLVERR;
			RG_DSEL: begin
				for (int i = 0; i < NDOUT; i++) begin
					if (wr_m[SEL_W*i +: SEL_W] > SEL_MAX)
						wr_resp = RESP_SLVERR;
				end
			end
			RG_ASGN: begin
				// position rows rank above rotor rows
				if (wr_mix || wr_blk)
					wr_resp = RESP_SLVERR;
				else if ((wr_m[NSRC-1:0] & ~act) != '0)
					wr_resp = RESP_SLVERR;
			end
			RG_ROTE: begin
				if ($signed(wr_m[ANG_W-1:0]) < ANG_MIN ||
				    $signed(wr_m[ANG_W-1:0]) > ANG_MAX)
					wr_resp = RESP_SLVERR;
			end
			default: wr_resp = RESP_DECERR;
		endcase
	end

	logic wr_take;
	assign wr_take = wr_do && (wr_resp == RESP_OKAY);

	// --------------------------------------------------------------
	// write channel handshake
	// --------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_q <= 1'b1;
			awaddr_q  <= '0;
		end else if (s_axi_awvalid && awready_q) begin
			awready_q <= 1'b0;
			awaddr_q  <= s_axi_awaddr;
		end else if (wr_do) begin
			awready_q <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wready_q <= 1'b1;
			wdata_q  <= 32'h0000_0000;
			wstrb_q  <= 4'h0;
		end else if (s_axi_wvalid && wready_q) begin
			wready_q <= 1'b0;
			wdata_q  <= s_axi_wdata;
			wstrb_q  <= s_axi_wstrb;
		end else if (wr_do) begin
			wready_q <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q  <= RESP_OKAY;
		end else if (wr_do) begin
			bvalid_q <= 1'b1;
			bresp_q  <= wr_resp;
		end else if (bvalid_q && s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// --------------------------------------------------------------
	// register storage
	// --------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= CTRL_RST;
			dsel_q <= DSEL_RST;
		end else if (wr_take && wr_rg == RG_CTRL) begin
			ctrl_q <= wr_m[15:0];
		end else if (wr_take && wr_rg == RG_DSEL) begin
			dsel_q <= wr_m[15:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int k = 0; k < NOUT; k++)
				asgn_q[k] <= ASGN_RST;
		end else if (wr_take && wr_rg == RG_ASGN) begin
			asgn_q[wr_k] <= wr_m[NSRC-1:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < 2*NCH; i++) begin
				pos_edge_q[i] <= EDGE_RST;
				rot_edge_q[i] <= EDGE_RST[ANG_W-1:0];
			end
		end else if (wr_take && wr_rg == RG_POSE) begin
			pos_edge_q[awaddr_q[4:2]] <= wr_m;
		end else if (wr_take && wr_rg == RG_ROTE) begin
			rot_edge_q[awaddr_q[4:2]] <= wr_m[ANG_W-1:0];
		end
	end

	// --------------------------------------------------------------
	// read channel
	// --------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_q <= 1'b1;
			rvalid_q  <= 1'b0;
			rresp_q   <= RESP_OKAY;
			rdata_q   <= 32'h0000_0000;
		end else if (s_axi_arvalid && arready_q) begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b1;
			rdata_q   <= rd_word(s_axi_araddr);
			rresp_q   <= (addr_region(s_axi_araddr) == RG_NONE) ?
			             RESP_DECERR : RESP_OKAY;
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_q  <= 1'b0;
			arready_q <= 1'b1;
		end
	end

	// --------------------------------------------------------------
	// channels and matrix
	// --------------------------------------------------------------
	genvar c;
	generate
		for (c = 0; c < NCH; c++) begin : g_ch
			pwt_win_cmp #(.W(POS_W)) u_pos (
				.aclk    (aclk),
				.aresetn (aresetn),
				.value   (act_pos),
				.lo      (pos_edge_q[2*c]),
				.hi      (pos_edge_q[2*c+1]),
				.inv     (inv[c]),
				.hit_q   (src_q[c])
			);
			// angle is already folded into one turn by the encoder
			pwt_win_cmp #(.W(ANG_W)) u_rot (
				.aclk    (aclk),
				.aresetn (aresetn),
				.value   (enc_angle),
				.lo      (rot_edge_q[2*c]),
				.hi      (rot_edge_q[2*c+1]),
				.inv     (inv[NCH+c]),
				.hit_q   (src_q[NCH+c])
			);
		end
		for (c = 0; c < NOUT; c++) begin : g_flat
			assign asgn_flat[c*NSRC +: NSRC] = asgn_q[c];
		end
	endgenerate

	pwt_or_matrix u_matrix (
		.aclk    (aclk),
		.aresetn (aresetn),
		.src     (src_q),
		.act     (act),
		.asgn    (asgn_flat),
		.trig_q  (trig_q)
	);

	// --------------------------------------------------------------
	// digital output function selectors
	// --------------------------------------------------------------
	genvar d;
	generate
		for (d = 0; d < NDOUT; d++) begin : g_dout
			logic [SEL_W-1:0] sel;
			assign sel = dsel_q[SEL_W*d +: SEL_W];

			always_ff @(posedge aclk) begin
				if (!aresetn)
					dout_q[d] <= 1'b0;
				else if (sel != '0 && sel <= SEL_MAX)
					dout_q[d] <= trig_q[sel[1:0] - 2'h1];
				else
					dout_q[d] <= 1'b0;
			end

			a_dout_none: assert property (
				@(posedge aclk) disable iff (!aresetn)
				(sel == '0) |=> !dout_q[d]
			) else $error("unselected digital output went high");

			a_dout_route: assert property (
				@(posedge aclk) disable iff (!aresetn)
				(sel == SEL_MAX && $stable(sel)) ##1 (sel == SEL_MAX)
				|-> (dout_q[d] == $past(trig_q[NOUT-1]))
			) else $error("digital output not following trigger four");
		end
	endgenerate

	assign trig_out      = trig_q;
	assign dout          = dout_q;
	assign s_axi_awready = awready_q;
	assign s_axi_wready  = wready_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rresp   = rresp_q;
	assign s_axi_rdata   = rdata_q;

	// --------------------------------------------------------------
	// checks
	// --------------------------------------------------------------
	generate
		for (c = 0; c < NOUT; c++) begin : g_chk
			a_group_nomix: assert property (
				@(posedge aclk) disable iff (!aresetn)
				!((|asgn_q[c][3:0]) && (|asgn_q[c][7:4]))
			) else $error("output mixes position and rotor groups");
		end
		for (c = 0; c < 2*NCH; c++) begin : g_ang
			a_angle_range: assert property (
				@(posedge aclk) disable iff (!aresetn)
				(rot_edge_q[c] >= ANG_MIN) && (rot_edge_q[c] <= ANG_MAX)
			) else $error("rotor edge outside half turn range");
		end
	endgenerate

	a_rotor_blocked: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(wr_do && wr_rg == RG_ASGN && wr_blk)
		|=> (bvalid_q && bresp_q == RESP_SLVERR)
	) else $error("rotor assign accepted over position assign");

	a_inactive_refused: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(wr_do && wr_rg == RG_ASGN && (wr_m[NSRC-1:0] & ~act) != '0)
		|=> (bresp_q == RESP_SLVERR)
	) else $error("inactive source assign accepted");

endmodule : pwt_top

/* File: rtl/pwt_win_cmp.sv */
// one window comparator channel with invert option
`timescale 1ns/10ps
module pwt_win_cmp
	import pwt_pkg::*;
#(
	parameter int W = 32
) (
	input  wire logic                aclk,
	input  wire logic                aresetn,
	input  wire logic signed [W-1:0] value,
	input  wire logic signed [W-1:0] lo,
	input  wire logic signed [W-1:0] hi,
	input  wire logic                inv,
	output logic                     hit_q
);

	always_ff @(posedge aclk) begin
		if (!aresetn)
			hit_q <= 1'b0;
		else
			hit_q <= ((value >= lo) && (value <= hi)) ^ inv;
	end

	// the sampled aresetn keeps the release edge out: hit_q is still
	// being reset there, so the next edge shows no compare result yet
	a_below_lower: assert property (
		@(posedge aclk) disable iff (!aresetn)
		aresetn && (value < lo) |=> (hit_q == $past(inv))
	) else $error("below lower edge gave wrong level");

	a_above_upper: assert property (
		@(posedge aclk) disable iff (!aresetn)
		aresetn && (value > hi) |=> (hit_q == $past(inv))
	) else $error("above upper edge gave wrong level");

	a_inside_window: assert property (
		@(posedge aclk) disable iff (!aresetn)
		aresetn && (value >= lo && value <= hi) |=> (hit_q != $past(inv))
	) else $error("inside window gave outside level");

endmodule : pwt_win_cmp

/* File: testbench/position_window_trigger_matrix_tb.sv */
// self-checking bench for the position window trigger matrix
`timescale 1ns/10ps
module position_window_trigger_matrix_tb
	import pwt_pkg::*;
;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic                    aclk, aresetn, load;
	logic [ADR_W-1:0]        awaddr, araddr;
	logic                    awvalid, wvalid, bready, arvalid, rready;
	logic                    awready, wready, bvalid, arready, rvalid;
	logic [31:0]             wdata, rdata, e;
	logic [3:0]              wstrb;
	logic [1:0]              bresp, rresp;
	logic [NOUT-1:0]         trig_out;
	logic [NDOUT-1:0]        dout;
	logic signed [POS_W-1:0] act_pos, pos_in, val;
	logic signed [ANG_W-1:0] enc_angle, ang_in;
	logic [31:0]             regs [0:31];
	logic [1:0]              qb [$];
	logic [33:0]             qr [$];
	int                      miscompares, compares, seed, k, av;

	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	pwt_top dut_u (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .act_pos(act_pos),
		.enc_angle(enc_angle), .trig_out(trig_out), .dout(dout));

	pwt_fb_model fb_u (.aclk(aclk), .aresetn(aresetn), .load(load),
		.pos_in(pos_in), .ang_in(ang_in), .act_pos(act_pos),
		.enc_angle(enc_angle));

	// ----------------------------------------------------------------
	// checking
	// ----------------------------------------------------------------
	task check(input logic [33:0] seen, input logic [33:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
		end
	endtask : check

	task close_out();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : close_out

	// responses are matched in order against the oldest note
	always @(posedge aclk) begin
		if (bvalid && bready)
			check({32'h0, bresp}, {32'h0, qb.pop_front()});
		if (rvalid && rready)
			check({rresp, rdata}, qr.pop_front());
	end

	initial begin
		#200000;
		miscompares++;
		close_out();
	end

	// ----------------------------------------------------------------
	// bus and feedback tasks
	// ----------------------------------------------------------------
	task axi_wr(input logic [ADR_W-1:0] a, input logic [31:0] d,
	            input logic [1:0] r);
		@(posedge aclk);
		qb.push_back(r);
		if (r === RESP_OKAY)
			regs[a[6:2]] = d;
		awaddr  <= a;
		wdata   <= d;
		wstrb   <= 4'hF;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
	endtask : axi_wr

	task axi_rd(input logic [ADR_W-1:0] a, input logic [31:0] d,
	            input logic [1:0] r);
		@(posedge aclk);
		qr.push_back({r, d});
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
	endtask : axi_rd

	function automatic logic [31:0] calc_stat();
		logic [7:0]         s;
		logic [3:0]         t, o, n;
		logic signed [31:0] v;
		for (int i = 0; i < 8; i++) begin
			v = act_pos;
			if (i >= 4)
				v = enc_angle;
			s[i] = ((v >= $signed(regs[8+2*i])) &&
			        (v <= $signed(regs[9+2*i]))) ^ regs[0][8+i];
		end
		for (int j = 0; j < 4; j++)
			t[j] = |(s & regs[0][7:0] & regs[4+j][7:0]);
		for (int j = 0; j < 4; j++) begin
			n = regs[3][4*j +: 4];
			o[j] = (n >= 4'h1 && n <= 4'h4) ? t[n-1] : 1'b0;
		end
		return {16'h0, o, t, s};
	endfunction : calc_stat

	task set_fb(input logic signed [31:0] p, input logic signed [15:0] g);
		@(posedge aclk);
		load   <= 1'b1;
		pos_in <= p;
		ang_in <= g;
		@(posedge aclk);
		load <= 1'b0;
		repeat (5) @(posedge aclk);
		e = calc_stat();
		check({30'h0, trig_out}, {30'h0, e[11:8]});
		check({30'h0, dout}, {30'h0, e[15:12]});
		axi_rd(ADDR_STAT, e, RESP_OKAY);
	endtask : set_fb

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		{aresetn, load, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata, wstrb, pos_in, ang_in} = '0;
		miscompares = 0;
		compares = 0;
		seed = 79;
		for (int i = 0; i < 32; i++)
			regs[i] = 32'h0000_0000;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		check({26'h0, trig_out, dout}, 34'h0_0000_0000);
		for (int i = 0; i < 24; i++)
			if (i != 1 && i != 2)
				axi_rd(8'(4*i), 32'h0000_0000, RESP_OKAY);
		axi_rd(8'h08, 32'h0000_0000, RESP_DECERR);
		axi_rd(8'h60, 32'h0000_0000, RESP_DECERR);
		axi_rd(8'h01, 32'h0000_0000, RESP_DECERR);
		axi_wr(ADDR_STAT, 32'h0000_FFFF, RESP_SLVERR);
		for (int n = 0; n < 4; n++) begin
			axi_wr(8'(8'h20 + 8*n), 32'(100*n), RESP_OKAY);
			axi_wr(8'(8'h24 + 8*n), 32'(100*n + 50), RESP_OKAY);
			axi_wr(8'(8'h40 + 8*n), 32'(-1800 + 900*n), RESP_OKAY);
			axi_wr(8'(8'h44 + 8*n), 32'(-1350 + 900*n), RESP_OKAY);
		end
		axi_wr(8'h44, 32'(1801), RESP_SLVERR);
		axi_wr(8'h40, 32'(-1801), RESP_SLVERR);
		axi_wr(ADDR_CTRL, 32'h0000_00F7, RESP_OKAY);
		axi_wr(8'h10, 32'h0000_0003, RESP_OKAY);
		axi_wr(8'h14, 32'h0000_0030, RESP_OKAY);
		axi_wr(8'h18, 32'h0000_0081, RESP_SLVERR);
		axi_wr(8'h10, 32'h0000_0010, RESP_SLVERR);
		axi_wr(8'h1C, 32'h0000_0008, RESP_SLVERR);
		axi_wr(8'h1C, 32'h0000_00C0, RESP_OKAY);
		axi_wr(8'h18, 32'h0000_0004, RESP_OKAY);
		axi_wr(ADDR_DSEL, 32'h0000_5123, RESP_SLVERR);
		axi_wr(ADDR_DSEL, 32'h0000_1423, RESP_OKAY);
		for (int i = 0; i < 24; i++)
			if (i != 1 && i != 2)
				axi_rd(8'(4*i), regs[i], RESP_OKAY);
		set_fb(32'sd25, 16'sd1900);
		axi_wr(8'h14, 32'h0000_0002, RESP_OKAY);
		for (int it = 0; it < 40; it++) begin
			if (it % 8 == 7)
				axi_wr(ADDR_CTRL, {16'h0, 16'($random(seed))}, RESP_OKAY);
			k = {$random(seed)} % 8;
			val = $signed(regs[8 + 2*k + ({$random(seed)} % 2)]);
			val = val + $signed({$random(seed)} % 3) - 1;
			av = $signed({$random(seed)} % 3601) - 1800;
			if (k < 4)
				set_fb(val, 16'(av));
			else
				set_fb(32'({$random(seed)} % 500), val[15:0]);
		end
		close_out();
	end
endmodule : position_window_trigger_matrix_tb

/* File: testbench/pwt_fb_model.sv */
// position feedback source model for the window trigger matrix
`timescale 1ns/10ps
module pwt_fb_model
	import pwt_pkg::*;
(
	input  wire logic                    aclk,
	input  wire logic                    aresetn,
	input  wire logic                    load,
	input  wire logic signed [POS_W-1:0] pos_in,
	input  wire logic signed [ANG_W-1:0] ang_in,
	output logic signed [POS_W-1:0]      act_pos,
	output logic signed [ANG_W-1:0]      enc_angle
);
	// ----------------------------------------------------------------
	// feedback registers
	// ----------------------------------------------------------------
	// the encoder reports the angle folded into one turn
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			act_pos   <= '0;
			enc_angle <= '0;
		end else if (load) begin
			act_pos <= pos_in;
			if (ang_in > ANG_MAX)
				enc_angle <= ang_in - 16'sd3600;
			else if (ang_in < ANG_MIN)
				enc_angle <= ang_in + 16'sd3600;
			else
				enc_angle <= ang_in;
		end
	end
endmodule : pwt_fb_model
